// File: pkg/sth_consts.svh
// Offsets, field positions, reset values and timing counts of the termination timing block
`ifndef STH_CONSTS_SVH
`define STH_CONSTS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define STH_OFF_MODE0 8'h00
`define STH_OFF_MODE1 8'h04
`define STH_OFF_MODE2 8'h08
`define STH_OFF_CTRL 8'h0c
`define STH_OFF_STATUS 8'h10

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define STH_MR0_KEEP_DLL 12
`define STH_MR0_CL_LSB 4
`define STH_MR1_AL_LSB 3
`define STH_MR1_NOM_B0 2
`define STH_MR1_NOM_B1 6
`define STH_MR1_NOM_B2 9
`define STH_MR2_CWL_LSB 3
`define STH_MR2_WR_LO 9
`define STH_MR2_WR_HI 10
`define STH_CTRL_DLL_LOCK 0
`define STH_CTRL_PWR_LSB 1
`define STH_ST_VIOL 3

// ------------------------------------------------------------
// Reset values and codes
// ------------------------------------------------------------
`define STH_RST_MODE 16'h0000
`define STH_RST_CTRL 3'h0
`define STH_AL_CL_MINUS1 2'h1
`define STH_AL_CL_MINUS2 2'h2

// ------------------------------------------------------------
// Timing counts in device clock cycles
// ------------------------------------------------------------
`define STH_CL_BASE 5'h04
`define STH_CWL_BASE 5'h05
`define STH_LAT_TRIM 5'h02
`define STH_LAT_MIN 5'h01
`define STH_HIGH_SHORT 3'h4
`define STH_HIGH_LONG 3'h6
`define STH_DEPTH 32

`endif

// File: pkg/sth_pkg.sv
// Types of the synchronous termination timing block
package sth_pkg;

    typedef enum logic [1:0] {
        STH_PWR_ACTIVE = 2'h0,
        STH_PWR_ACT_PD = 2'h1,
        STH_PWR_PRE_PD = 2'h3
    } sth_power_t;

    typedef struct packed {
        logic [31:0][2:0] stage;
    } sth_dline_t;

    typedef struct packed {
        logic [1:0] ck_s;
        logic ck_q;
        logic [1:0] pin_s;
        logic [1:0] wr_s;
        logic [1:0] chop_s;
        logic pin_prev;
        logic [15:0] mode0;
        logic [15:0] mode1;
        logic [15:0] mode2;
        logic [2:0] ctrl;
        logic viol;
        logic [2:0] rem;
        logic wsel;
        logic [2:0] wcnt;
        logic term_on;
        logic term_wr;
        logic [31:0] prdata;
        logic slverr;
    } sth_state_t;

endpackage : sth_pkg

// File: rtl/sth_delay_line.sv
// Delay line of per-edge pin samples, tapped at a programmable depth
`timescale 1ns/1ps
`include "sth_consts.svh"

module sth_delay_line
    import sth_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic shift,
    input wire logic [2:0] din,
    input wire logic [4:0] tap,
    output logic [2:0] dout
);

    sth_dline_t cur;
    sth_dline_t next_cur;

    always_comb begin
        next_cur = cur;
        if (shift) begin
            next_cur.stage[0] = din;
            for (int i = 1; i < `STH_DEPTH; i++) begin
                next_cur.stage[i] = cur.stage[i-1];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // Tap 1 is the sample taken at the previous device clock edge
    assign dout = cur.stage[5'(tap - `STH_LAT_MIN)];

endmodule : sth_delay_line

// File: rtl/sth_top.sv
// Synchronous on-die termination timing with dynamic write termination, APB registers
//
// Notes on behaviour
// RL1: Synchronous timing runs only with the loop locked and nominal or write termination enabled.
// RL2: It runs when active or idle, in active power-down, and in precharge power-down if kept.
// RL3: Termination turns on the on-latency in device clocks after the pin is sampled high.
// RL4: Termination turns off the off-latency in device clocks after the pin is sampled low.
// RL5: On-latency and off-latency both equal total write latency minus two.
// RL6: The internal pin copy is delayed by the additive latency of mode register one bits 4:3.
// RL7: Each latency is CAS write delay plus additive latency minus two.
// RL8: The controller holds the pin high at least four clocks after raising it.
// RL9: After a write with the pin high it holds it four clocks for a chop, six for a full burst.
// RL10: Both minimum-high counts run to the pin first sampled low and both must be met.
// RL11: With only write termination enabled the controller may leave the pin high.
// RL12: Dynamic switching is active when either write-termination bit of mode register two is set.
// RL13: Write termination replaces nominal one write latency minus two after a write.
// RL14: Nominal returns the off-latency plus six (full) or plus four (chop) after the write.
// RL15: With both terminations disabled, termination stays off whatever the pin does.
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "sth_consts.svh"

module sth_top
    import sth_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic DEV_CK,
    input wire logic TERMINATION_CONTROL_PIN,
    input wire logic WRITE_CMD,
    input wire logic CHOP_FOUR_BURST,
    output logic TERM_ON,
    output logic TERM_WRITE_SEL
);

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic [4:0] sth_additive(input logic [1:0] al_code,
                                                input logic [2:0] cl_code);
        logic [4:0] cl;
        cl = 5'(cl_code) + `STH_CL_BASE;
        if (al_code == `STH_AL_CL_MINUS1) begin
            sth_additive = cl - 5'h01;
        end else if (al_code == `STH_AL_CL_MINUS2) begin
            sth_additive = cl - 5'h02;
        end else begin
            sth_additive = 5'h00;
        end
    endfunction : sth_additive

    function automatic logic [2:0] sth_hold(input logic chop);
        sth_hold = chop ? (`STH_HIGH_SHORT - 3'h1) : (`STH_HIGH_LONG - 3'h1);
    endfunction : sth_hold

    function automatic logic [2:0] sth_max3(input logic [2:0] a, input logic [2:0] b);
        sth_max3 = (a > b) ? a : b;
    endfunction : sth_max3

    // ------------------------------------------------------------
    // State and derived values
    // ------------------------------------------------------------
    sth_state_t cur;
    sth_state_t next_cur;
    logic ck_rise;
    logic nom_en;
    logic wr_en;
    logic sync_mode;
    sth_power_t pwr;
    logic [4:0] add_lat;
    logic [4:0] cas_write_delay;
    logic [4:0] lat_raw;
    logic [4:0] lat;
    logic [2:0] dl_out;
    logic setup;
    logic wr_status;

    // Sampling the device clock costs up to 30 ns of lag, small against its period
    assign ck_rise = cur.ck_s[1] & ~cur.ck_q;
    assign nom_en = cur.mode1[`STH_MR1_NOM_B0] | cur.mode1[`STH_MR1_NOM_B1]
                  | cur.mode1[`STH_MR1_NOM_B2];
    assign wr_en = cur.mode2[`STH_MR2_WR_LO] | cur.mode2[`STH_MR2_WR_HI]; // [RL12]
    assign pwr = sth_power_t'(cur.ctrl[`STH_CTRL_PWR_LSB +: 2]);
    // Precharge power-down without the loop kept falls to the asynchronous mode, not built here
    assign sync_mode = cur.ctrl[`STH_CTRL_DLL_LOCK] & (nom_en | wr_en)           // [RL1]
                     & ((pwr != STH_PWR_PRE_PD) | cur.mode0[`STH_MR0_KEEP_DLL]); // [RL2]

    assign add_lat = sth_additive(cur.mode1[`STH_MR1_AL_LSB +: 2],
                                  cur.mode0[`STH_MR0_CL_LSB +: 3]); // [RL6]
    assign cas_write_delay = 5'(cur.mode2[`STH_MR2_CWL_LSB +: 3]) + `STH_CWL_BASE;
    assign lat_raw = cas_write_delay + add_lat - `STH_LAT_TRIM; // [RL5] [RL7]
    assign lat = (lat_raw < `STH_LAT_MIN) ? `STH_LAT_MIN : lat_raw;

    // ------------------------------------------------------------
    // Pin history, one entry per device clock edge
    // ------------------------------------------------------------
    sth_delay_line u_dline (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .shift(ck_rise),
        .din({cur.chop_s[1], cur.wr_s[1], cur.pin_s[1]}),
        .tap(lat),
        .dout(dl_out)
    );

    assign setup = PSEL & ~PENABLE;
    assign wr_status = PSEL & PENABLE & PWRITE & (PADDR == `STH_OFF_STATUS);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [2:0] need;
        next_cur = cur;
        need = 3'h0;
        next_cur.ck_s = {cur.ck_s[0], DEV_CK};
        next_cur.ck_q = cur.ck_s[1];
        next_cur.pin_s = {cur.pin_s[0], TERMINATION_CONTROL_PIN};
        next_cur.wr_s = {cur.wr_s[0], WRITE_CMD};
        next_cur.chop_s = {cur.chop_s[0], CHOP_FOUR_BURST};

        if (ck_rise) begin
            // Write termination window after the delayed write arrives
            if (sync_mode && wr_en && dl_out[1]) begin
                next_cur.wsel = 1'b1; // [RL13]
                next_cur.wcnt = sth_hold(dl_out[2]); // [RL14]
            end else if (cur.wcnt != 3'h0) begin
                next_cur.wcnt = cur.wcnt - 3'h1;
            end else begin
                next_cur.wsel = 1'b0; // [RL14]
            end
            // Delayed pin level drives on and off alike
            next_cur.term_on = dl_out[0] & (nom_en | next_cur.wsel); // [RL3] [RL4]

            // Watch the controller's minimum-high duty
            if (cur.pin_s[1]) begin
                need = (cur.rem != 3'h0) ? cur.rem - 3'h1 : 3'h0;
                if (!cur.pin_prev) begin
                    need = sth_max3(need, `STH_HIGH_SHORT - 3'h1); // [RL8] [RL10]
                end
                if (cur.wr_s[1]) begin
                    need = sth_max3(need, sth_hold(cur.chop_s[1])); // [RL9] [RL10]
                end
            end
            next_cur.rem = need;
            next_cur.pin_prev = cur.pin_s[1];
        end

        if (!sync_mode || !wr_en) begin
            next_cur.wsel = 1'b0;
            next_cur.wcnt = 3'h0;
        end
        if (!sync_mode) begin
            next_cur.term_on = 1'b0; // [RL15]
        end
        next_cur.term_wr = next_cur.term_on & next_cur.wsel;

        // Register writes
        if (PSEL && PENABLE && PWRITE) begin
            if (PADDR == `STH_OFF_MODE0) begin
                next_cur.mode0 = PWDATA[15:0];
            end else if (PADDR == `STH_OFF_MODE1) begin
                next_cur.mode1 = PWDATA[15:0];
            end else if (PADDR == `STH_OFF_MODE2) begin
                next_cur.mode2 = PWDATA[15:0];
            end else if (PADDR == `STH_OFF_CTRL) begin
                next_cur.ctrl = PWDATA[2:0];
            end
        end
        // A violation in the clearing cycle still sticks
        next_cur.viol = (cur.viol & ~(wr_status & PWDATA[`STH_ST_VIOL]))
                      | (ck_rise & ~cur.pin_s[1] & (cur.rem != 3'h0)); // [RL10]

        // Read data is captured in the setup cycle
        if (setup) begin
            next_cur.slverr = 1'b0;
            if (PADDR == `STH_OFF_MODE0) begin
                next_cur.prdata = {16'h0000, cur.mode0};
            end else if (PADDR == `STH_OFF_MODE1) begin
                next_cur.prdata = {16'h0000, cur.mode1};
            end else if (PADDR == `STH_OFF_MODE2) begin
                next_cur.prdata = {16'h0000, cur.mode2};
            end else if (PADDR == `STH_OFF_CTRL) begin
                next_cur.prdata = {29'h00000000, cur.ctrl};
            end else if (PADDR == `STH_OFF_STATUS) begin
                next_cur.prdata = {23'h000000, lat, cur.viol, cur.term_wr, cur.term_on,
                                   sync_mode};
            end else begin
                next_cur.prdata = 32'h00000000;
                next_cur.slverr = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            cur <= '0;
            cur.mode0 <= `STH_RST_MODE;
            cur.mode1 <= `STH_RST_MODE;
            cur.mode2 <= `STH_RST_MODE;
            cur.ctrl <= `STH_RST_CTRL;
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign PRDATA = cur.prdata;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & cur.slverr;
    assign TERM_ON = cur.term_on;
    assign TERM_WRITE_SEL = cur.term_wr;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);

    chk_sync_gate: assert property (!sync_mode |=> !TERM_ON && !TERM_WRITE_SEL) // [RL1]
        else $error("termination active outside synchronous mode");
    chk_pd_gate: assert property ( // [RL2]
        (pwr == STH_PWR_PRE_PD && !cur.mode0[`STH_MR0_KEEP_DLL]) |-> !sync_mode)
        else $error("synchronous mode in precharge power-down without loop");
    chk_turn_on: assert property ( // [RL3]
        (ck_rise && sync_mode && nom_en && dl_out[0]) |=> TERM_ON)
        else $error("termination did not turn on after latency");
    chk_turn_off: assert property (ck_rise && !dl_out[0] |=> !TERM_ON) // [RL4]
        else $error("termination did not turn off after latency");
    chk_latency_sum: assert property ( // [RL7]
        (cas_write_delay + add_lat >= 5'h03) |-> (lat + 5'h02 == cas_write_delay + add_lat))
        else $error("latency differs from write latency minus two");
    chk_write_switch: assert property ( // [RL13]
        (ck_rise && sync_mode && wr_en && dl_out[1]) |=> cur.wsel && cur.wcnt != 3'h0)
        else $error("write termination did not start");
    chk_write_revert: assert property ( // [RL14]
        $fell(cur.wsel) |-> $past(cur.wcnt) == 3'h0 || !$past(sync_mode && wr_en))
        else $error("write termination ended early");
    chk_dyn_off: assert property (!wr_en |=> !TERM_WRITE_SEL) // [RL12]
        else $error("write termination without dynamic mode");
    chk_high_viol: assert property ( // [RL10]
        (ck_rise && !cur.pin_s[1] && cur.rem != 3'h0) |=> cur.viol)
        else $error("minimum-high breach not flagged");
    chk_both_off: assert property (!(nom_en || wr_en) |=> !TERM_ON) // [RL15]
        else $error("termination on with both disabled");

    // Mode gating, read straight from the decoded fields
    chk_lock_needed: assert property (!cur.ctrl[`STH_CTRL_DLL_LOCK] |-> !sync_mode) // [RL1]
        else $error("synchronous mode without a locked loop");
    chk_both_disabled: assert property (!(nom_en || wr_en) |-> !sync_mode) // [RL15]
        else $error("synchronous mode with both terminations disabled");
    chk_active_pd: assert property ( // [RL2]
        (cur.ctrl[`STH_CTRL_DLL_LOCK] && (nom_en || wr_en) && pwr == STH_PWR_ACT_PD)
            |-> sync_mode)
        else $error("active power-down left synchronous mode");

    // In synchronous mode TERM_ON moves only at a detected device clock edge; a stray move would shift the latency
    chk_on_stands: assert property ((!ck_rise && sync_mode) |=> $stable(TERM_ON)) // [RL3] [RL4]
        else $error("termination changed between device clock edges");
    chk_wr_implies_on: assert property (TERM_WRITE_SEL |-> TERM_ON) // [RL13]
        else $error("write termination selected while termination is off");

    // Write window length and the countdown behind it
    chk_chop_span: assert property ( // [RL14]
        (ck_rise && sync_mode && wr_en && dl_out[1] && dl_out[2])
            |=> cur.wcnt == `STH_HIGH_SHORT - 3'h1)
        else $error("chop write window has the wrong length");
    chk_full_span: assert property ( // [RL14]
        (ck_rise && sync_mode && wr_en && dl_out[1] && !dl_out[2])
            |=> cur.wcnt == `STH_HIGH_LONG - 3'h1)
        else $error("full write window has the wrong length");
    chk_wsel_count: assert property ( // [RL14]
        (ck_rise && sync_mode && wr_en && cur.wsel && cur.wcnt != 3'h0 && !dl_out[1])
            |=> cur.wsel && cur.wcnt == $past(cur.wcnt) - 3'h1)
        else $error("write window countdown skipped a step");

    // Minimum-high watch: arming, stickiness and clearing
    chk_rise_arm: assert property ( // [RL10]
        (ck_rise && cur.pin_s[1] && !cur.pin_prev) |=> cur.rem >= `STH_HIGH_SHORT - 3'h1)
        else $error("minimum-high count not armed on the rise");
    chk_write_arm: assert property ( // [RL10]
        (ck_rise && cur.pin_s[1] && cur.wr_s[1] && !cur.chop_s[1])
            |=> cur.rem == `STH_HIGH_LONG - 3'h1)
        else $error("minimum-high count not armed by a full write");
    chk_viol_sticky: assert property ( // [RL10]
        (cur.viol && !(wr_status && PWDATA[`STH_ST_VIOL])) |=> cur.viol)
        else $error("violation flag dropped without a clear");
    chk_viol_clear: assert property ( // [RL10]
        (wr_status && PWDATA[`STH_ST_VIOL] && !(ck_rise && !cur.pin_s[1] && cur.rem != 3'h0))
            |=> !cur.viol)
        else $error("violation flag not cleared");

    cov_term_on: cover property ($rose(TERM_ON));
    cov_write_sel: cover property ($rose(TERM_WRITE_SEL));
    cov_viol: cover property ($rose(cur.viol));
    cov_chop_write: cover property (ck_rise && dl_out[1] && dl_out[2] && sync_mode);
    cov_pd_kept: cover property (pwr == STH_PWR_PRE_PD && sync_mode);

endmodule : sth_top

// File: tb/sth_ctrl_model.sv
// Memory controller model: device clock, termination pin and write commands
`timescale 1ns/1ps

module sth_ctrl_model (
    input wire logic run,
    output logic dev_ck,
    output logic pin,
    output logic wr,
    output logic chop
);
    initial begin
        dev_ck = 1'b0;
        pin = 1'b0;
        wr = 1'b0;
        chop = 1'b0;
    end

    // Clock runs only within a frame and parks low between frames
    always #62.5 dev_ck <= run ? ~dev_ck : 1'b0;

    // Lines change at the falling edge so they are stable around each rising edge
    task automatic tick(input logic p, input logic w, input logic c);
        pin <= p;
        wr <= w;
        // Burst kind means nothing without a write, so it never rests at the last value
        chop <= w ? c : ~chop;
        @(posedge dev_ck);
        @(negedge dev_ck);
    endtask : tick
endmodule : sth_ctrl_model

// File: tb/testbench.sv
// Self-checking bench for the synchronous termination timing block
`timescale 1ns/1ps
`include "sth_consts.svh"

module testbench;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic run = 1'b0;
    wire logic dev_ck;
    wire logic pin;
    wire logic wr;
    wire logic chop;
    logic term_on;
    logic term_wsel;
    int fail_count = 0;
    int checked = 0;

    always #5 clk_sys = ~clk_sys;

    sth_top u_dut (.CLK_SYS(clk_sys), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .DEV_CK(dev_ck), .TERMINATION_CONTROL_PIN(pin), .WRITE_CMD(wr),
        .CHOP_FOUR_BURST(chop), .TERM_ON(term_on), .TERM_WRITE_SEL(term_wsel));

    sth_ctrl_model u_ctrl (.run(run), .dev_ck(dev_ck), .pin(pin), .wr(wr), .chop(chop));

    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
    endtask : rd_chk

    task automatic cfg(input logic [15:0] m0, m1, m2, input logic [2:0] c);
        logic [31:0] r;
        logic e;
        apb(1'b1, `STH_OFF_MODE0, {16'h0, m0}, r, e);
        apb(1'b1, `STH_OFF_MODE1, {16'h0, m1}, r, e);
        apb(1'b1, `STH_OFF_MODE2, {16'h0, m2}, r, e);
        apb(1'b1, `STH_OFF_CTRL, {29'h0, c}, r, e);
    endtask : cfg

    // Drives one frame of 33 device edges, one idle edge then 32 pattern edges; bit k of each pattern belongs to pattern edge k
    task automatic play(input logic [31:0] pv, wv, cv, input int l, input logic nom, dyn, sy);
        logic ws;
        logic on;
        run = 1'b1;
        u_ctrl.tick(1'b0, 1'b0, 1'b0);
        for (int k = 0; k < 32; k++) begin
            u_ctrl.tick(pv[k], wv[k], cv[k]);
            ws = 1'b0;
            for (int n = 0; n <= k; n++) begin
                if (wv[n] && k >= n + l && k < n + l + (cv[n] ? 4 : 6)) ws = sy & dyn;
            end
            on = sy && k >= l && pv[k - l] && (nom || ws);
            chk({30'h0, term_wsel, term_on}, {30'h0, on && ws, on});
        end
        run = 1'b0;
    endtask : play

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 4; i++) rd_chk(8'(i * 4), 32'h0);
        rd_chk(`STH_OFF_STATUS, 32'h00000030);
        apb(1'b0, 8'h14, 32'h0, r, e);
        chk(r, 32'h0);
        chk({31'h0, e}, 32'h00000001);
    endtask : t_reset

    task automatic t_nominal();
        cfg(16'h0000, 16'h0004, 16'h0000, 3'h1);
        rd_chk(`STH_OFF_STATUS, 32'h00000031);
        play(32'h0000ff0f, 32'h00000200, 32'h0, 3, 1'b1, 1'b0, 1'b1);
    endtask : t_nominal

    task automatic t_dynamic();
        logic [15:0] m2 [2] = '{16'h0200, 16'h0400};
        for (int i = 0; i < 2; i++) begin
            cfg(16'h0000, 16'h0004, m2[i], 3'h1);
            play(32'h0003f0ff, 32'h00002002, 32'h00002000, 3, 1'b1, 1'b1, 1'b1);
        end
    endtask : t_dynamic

    task automatic t_write_only();
        cfg(16'h0000, 16'h0000, 16'h0200, 3'h1);
        play(32'h000fffff, 32'h00000104, 32'h00000100, 3, 1'b0, 1'b1, 1'b1);
        rd_chk(`STH_OFF_STATUS, 32'h00000031);
    endtask : t_write_only

    task automatic t_additive();
        cfg(16'h0000, 16'h000c, 16'h0200, 3'h1);
        rd_chk(`STH_OFF_STATUS, 32'h00000061);
        play(32'h0000ff0f, 32'h00000200, 32'h0, 6, 1'b1, 1'b1, 1'b1);
        cfg(16'h0010, 16'h0014, 16'h0008, 3'h1);
        rd_chk(`STH_OFF_STATUS, 32'h00000071);
        play(32'h0000000f, 32'h0, 32'h0, 7, 1'b1, 1'b0, 1'b1);
    endtask : t_additive

    task automatic t_states();
        logic [15:0] m0 [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h1000};
        logic [15:0] m1 [5] = '{16'h0004, 16'h0000, 16'h0040, 16'h0004, 16'h0200};
        logic [2:0] ct [5] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h7};
        logic sy [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 5; i++) begin
            cfg(m0[i], m1[i], 16'h0000, ct[i]);
            apb(1'b0, `STH_OFF_STATUS, 32'h0, r, e);
            chk({31'h0, r[0]}, {31'h0, sy[i]});
            play(32'h0000000f, 32'h0, 32'h0, 3, 1'b1, 1'b0, sy[i]);
        end
    endtask : t_states

    task automatic t_violation();
        logic [31:0] r;
        logic e;
        cfg(16'h0000, 16'h0004, 16'h0000, 3'h1);
        play(32'h00000003, 32'h0, 32'h0, 3, 1'b1, 1'b0, 1'b1);
        rd_chk(`STH_OFF_STATUS, 32'h00000039);
        apb(1'b1, `STH_OFF_STATUS, 32'h00000008, r, e);
        rd_chk(`STH_OFF_STATUS, 32'h00000031);
        // High for six edges with a full write at the second: long enough from the rise, too short from the write
        play(32'h0000003f, 32'h00000002, 32'h0, 3, 1'b1, 1'b0, 1'b1);
        rd_chk(`STH_OFF_STATUS, 32'h00000039);
    endtask : t_violation

    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    initial begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_reset();
        t_nominal();
        t_dynamic();
        t_write_only();
        t_additive();
        t_states();
        t_violation();
        results();
    end

    // Thirteen frames of 33 device edges are needed; this leaves ample margin
    initial begin
        #500000;
        fail_count++;
        results();
    end
endmodule : testbench
